// >>> design/pxb_defs.vh
// register map, field positions, reset values and signal slots of the port crossbar
`ifndef PXB_DEFS_VH
`define PXB_DEFS_VH

// register indices; wishbone byte address is four times the index
`define PXB_IDX_XBAR0      8'hE1
`define PXB_IDX_XBAR1      8'hE2
`define PXB_IDX_CTRL       8'hE3
`define PXB_IDX_PB_MODE    8'hAD
`define PXB_IDX_PC_MODE    8'hAE
`define PXB_IDX_STATUS     8'hE8

// reset values
`define PXB_RST_XBAR       8'h00
`define PXB_RST_CTRL       8'h00
`define PXB_RST_MODE       8'hFF

// crossbar_enable_0 fields
`define PXB_X0_CMP_A       7
`define PXB_X0_EXT_CLK     6
`define PXB_X0_MOD_HI      5
`define PXB_X0_MOD_LO      3
`define PXB_X0_ASYNC_A     2
`define PXB_X0_SYNC        1
`define PXB_X0_TWO_WIRE    0

// crossbar_enable_1 fields
`define PXB_X1_INV_CLK     7
`define PXB_X1_TMR_C_CAP   6
`define PXB_X1_TMR_C_CNT   5
`define PXB_X1_IRQ_B       4
`define PXB_X1_TMR_B_CNT   3
`define PXB_X1_IRQ_A       2
`define PXB_X1_TMR_A_CNT   1
`define PXB_X1_CMP_B       0

// control register: global enable bit
`define PXB_CTRL_GLOBAL    6

// largest effective module count; a larger field value is clipped to it
`define PXB_MOD_MAX        3'h6

// peripheral signal slots, in allocation priority order
`define PXB_SIG_TX         0
`define PXB_SIG_RX         1
`define PXB_SIG_SCK        2
`define PXB_SIG_MISO       3
`define PXB_SIG_MOSI       4
`define PXB_SIG_NSS        5
`define PXB_SIG_SDA        6
`define PXB_SIG_SCL        7
`define PXB_SIG_MOD0       8
`define PXB_SIG_EXT_CLK    14
`define PXB_SIG_CMP_A      15
`define PXB_SIG_CMP_B      16
`define PXB_SIG_TMR_A      17
`define PXB_SIG_IRQ_A      18
`define PXB_SIG_TMR_B      19
`define PXB_SIG_IRQ_B      20
`define PXB_SIG_TMR_C      21
`define PXB_SIG_TMR_C_CAP  22
`define PXB_SIG_INV_CLK    23

// slots that may drive a pin; the others are input only
`define PXB_OUT_MASK       24'h81BFFD

`endif

// >>> design/pxb_crossbar.v
// port crossbar: priority allocation of peripheral signals to port pins, wishbone registers
//
// Behaviour
// - crossbar_enable_0 bit 7 routes comparator A output to an allocated pin.
// - crossbar_enable_0 bit 6 routes the counter array external clock input.
// - module count field bits 5..3: N up to 6 routes module lines 0..N-1, seven acts as six, zero routes none.
// - bit 2 puts async transmit on port 0 pin 0, receive on pin 1.
// - bit 1 routes sync serial clock, data lines; select only in 4-wire mode.
// - bit 0 routes two-wire data and clock lines to two pins.
// - crossbar_enable_1 bit 7 drives inverted system clock onto an allocated pin.
// - bit 6 routes timer C capture input, bit 5 timer C count input.
// - bit 3 routes timer B count input, bit 1 timer A count input.
// - bit 4 routes external irq B input, bit 2 external irq A input.
// - crossbar_enable_1 bit 0 routes comparator B output to an allocated pin.
// - enabled signals take lowest free non-skipped pins in fixed priority order.
// - analog-mode pins are skipped; the next signal takes the following pin.
// - all pin drivers stay off until the global crossbar enable is set.
//
// Bus timing
// a request is taken on the first edge that sees cyc and stb with no answer pending;
// ack (or err for an unmapped index) is registered, so it stands in the next cycle;
// the write itself lands on the edge where the master samples ack, so a master that
// drops the request early never half-writes a register
// only byte lane 0 carries data; a write with sel[0] low is answered but ignored
//
// Register indices (byte address is four times the index)
// 0xE1 crossbar_enable_0, 0xE2 crossbar_enable_1, 0xE3 control (bit 6 global enable)
// 0xAD port 1 input mode, 0xAE port 2 input mode, both reset to all digital
// 0xE8 status, read only: bits 5..0 pins allocated, bit 6 overflow
// any other index ends the cycle with err and changes nothing
//
// Pin numbering
// pin p is port (p / 8), bit (p % 8); ports 0 and 3 are never skipped
// ports 1 and 2 follow their input mode registers: a zero bit is analog and skipped
//
// Slot order (allocation priority, highest first)
// async tx, async rx, sync clock, sync in, sync out, sync select,
// two-wire data, two-wire clock, array module lines 0..5, array external clock,
// comparator A, comparator B, timer A, irq A, timer B, irq B,
// timer C count, timer C capture, inverted system clock
//
// Allocation walk
// each enabled slot gets a rank: the number of enabled slots of higher priority
// pins are scanned from 0 upward, skipping analog pins, and each usable pin
// takes the slot whose rank equals the count of usable pins before it
// this is a pure comparison network, so its depth grows with pins times slots;
// at 24 slots and 32 pins it is traded against a sequential allocator's latency
//
// Hazards
// the map is rebuilt every cycle from the registers; a change of the enables
// reshuffles every lower-priority pin, so software should set the global enable last
// input-only slots never turn a pin driver on, whatever their peripheral asks for
// signals beyond the last usable pin get no pin and raise the overflow status flag
// unrouted peripheral inputs read high so that active-low irq inputs stay idle
//
// Limitations
// port latches and output modes live outside this block; an unallocated pin is not driven
// inputs are routed even while the global enable is clear, only drivers are held off
// the map lags a register write by one cycle, since it is registered
//
// Design decision made here: the Wishbone slave port.
`include "pxb_defs.vh"

module pxb_crossbar #(
    parameter AW = 10,                      // wishbone byte address width
    parameter NPIN = 32,                    // pins on ports 0..3
    parameter NSIG = 24                     // peripheral signal slots
) (
    input wire mclk,                        // system clock
    input wire reset,                       // async reset, active high
    input wire wb_cyc_i,                    // bus cycle
    input wire wb_stb_i,                    // strobe
    input wire wb_we_i,                     // write enable
    input wire [AW-1:0] wb_adr_i,           // byte address
    input wire [3:0] wb_sel_i,              // byte enables
    input wire [31:0] wb_dat_i,             // write data
    output reg [31:0] wb_dat_o,             // read data
    output reg wb_ack_o,                    // normal end of cycle
    output reg wb_err_o,                    // unmapped address
    input wire sync_four_wire,              // sync serial port in 4-wire mode
    input wire [NSIG-1:0] periph_out,       // peripheral drive values, by slot
    input wire [NSIG-1:0] periph_oe,        // peripheral drive enables, by slot
    output reg [NSIG-1:0] periph_in,        // pin levels back to peripherals
    input wire [NPIN-1:0] pin_in,           // pin levels
    output reg [NPIN-1:0] pin_out,          // pin drive values
    output reg [NPIN-1:0] pin_oe            // pin drive enables
);

    reg [7:0] crossbar_enable_0_q;
    reg [7:0] crossbar_enable_1_q;
    reg [7:0] ctrl_q;
    reg [7:0] port_b_input_mode_q;
    reg [7:0] port_c_input_mode_q;
    reg [NPIN*5-1:0] pin_map_q;
    reg [NPIN-1:0] pin_act_q;
    reg overflow_q;
    reg [NPIN*5-1:0] pin_map_d;
    reg [NPIN-1:0] pin_act_d;
    reg overflow_d;
    reg [NSIG-1:0] sig_en;
    reg [NSIG*5-1:0] sig_rank;
    reg [NPIN-1:0] skip;
    reg [5:0] rank_cnt;
    reg [5:0] pin_cnt;
    reg [5:0] used_cnt;
    reg [2:0] array_module_count;
    reg [4:0] sel;
    reg [31:0] rd_data;
    reg hit;
    wire crossbar_global_enable;
    wire [7:0] reg_idx;
    wire req;
    wire wr_strobe;
    wire [7:0] status_byte;
    wire [2:0] module_field;
    wire [NSIG-1:0] out_mask;
    integer i;
    integer p;

    // a register index from a byte address; low two bits select a lane
    function [7:0] addr_index;
        input [AW-1:0] a;
        begin
            addr_index = a[9:2];
        end
    endfunction

    // slot number from the packed pin map
    function [4:0] map_field;
        input [NPIN*5-1:0] m;
        input integer k;
        begin
            map_field = m[k*5 +: 5];
        end
    endfunction

    // module count clipped to the six lines that exist; seven acts as six
    function [2:0] clip_count;
        input [2:0] c;
        begin
            if (c > `PXB_MOD_MAX)
                clip_count = `PXB_MOD_MAX;
            else
                clip_count = c;
        end
    endfunction

    // drive capability of a slot; slots past the mask never drive
    function slot_drives;
        input [NSIG-1:0] mask;
        input [4:0] s;
        begin
            if (s < NSIG)
                slot_drives = mask[s];
            else
                slot_drives = 1'b0;
        end
    endfunction

    // one module line enable: line k is routed when the count exceeds k
    function line_en;
        input [2:0] cnt;
        input integer k;
        begin
            line_en = (cnt > k[2:0]);
        end
    endfunction

    assign req = wb_cyc_i & wb_stb_i;
    assign reg_idx = addr_index(wb_adr_i);
    assign crossbar_global_enable = ctrl_q[`PXB_CTRL_GLOBAL];
    // a write lands on the edge where the master samples ack
    assign wr_strobe = req & wb_we_i & wb_ack_o & wb_sel_i[0];
    // status byte: overflow flag above the allocated pin count
    assign status_byte = {1'b0, overflow_q, used_cnt};
    assign module_field = crossbar_enable_0_q[`PXB_X0_MOD_HI:`PXB_X0_MOD_LO];
    // slot drive mask at the slot count
    assign out_mask = `PXB_OUT_MASK;

    // address decode and read mux; narrow registers sit in the low byte
    always @* begin
        hit = 1'b1;
        rd_data = 32'h00000000;
        case (reg_idx)
            `PXB_IDX_XBAR0: rd_data[7:0] = crossbar_enable_0_q;
            `PXB_IDX_XBAR1: rd_data[7:0] = crossbar_enable_1_q;
            `PXB_IDX_CTRL: rd_data[7:0] = ctrl_q;
            `PXB_IDX_PB_MODE: rd_data[7:0] = port_b_input_mode_q;
            `PXB_IDX_PC_MODE: rd_data[7:0] = port_c_input_mode_q;
            `PXB_IDX_STATUS: rd_data[7:0] = status_byte;
            default: hit = 1'b0;
        endcase
    end

    // ack one cycle after the request; write lands on the ack edge
    // the answer blocks a new take only on its own sampling edge, so a request held past ack is taken again on the next edge
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req & hit & ~wb_ack_o & ~wb_err_o;
            wb_err_o <= req & ~hit & ~wb_ack_o & ~wb_err_o;
            if (req & ~wb_ack_o & ~wb_err_o)
                wb_dat_o <= rd_data;
        end
    end

    // register writes; only byte lane 0 carries data
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            crossbar_enable_0_q <= `PXB_RST_XBAR;
            crossbar_enable_1_q <= `PXB_RST_XBAR;
            ctrl_q <= `PXB_RST_CTRL;
            port_b_input_mode_q <= `PXB_RST_MODE;
            port_c_input_mode_q <= `PXB_RST_MODE;
        end else if (wr_strobe) begin
            case (reg_idx)
                `PXB_IDX_XBAR0: crossbar_enable_0_q <= wb_dat_i[7:0];
                `PXB_IDX_XBAR1: crossbar_enable_1_q <= wb_dat_i[7:0];
                `PXB_IDX_CTRL: ctrl_q <= {1'b0, wb_dat_i[6], 6'h00};
                `PXB_IDX_PB_MODE: port_b_input_mode_q <= wb_dat_i[7:0];
                `PXB_IDX_PC_MODE: port_c_input_mode_q <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // per-slot enables; count 7 saturates to six lines
    always @* begin
        array_module_count = clip_count(module_field);
        sig_en = {NSIG{1'b0}};
        sig_en[`PXB_SIG_TX] = crossbar_enable_0_q[`PXB_X0_ASYNC_A];
        sig_en[`PXB_SIG_RX] = crossbar_enable_0_q[`PXB_X0_ASYNC_A];
        sig_en[`PXB_SIG_SCK] = crossbar_enable_0_q[`PXB_X0_SYNC];
        sig_en[`PXB_SIG_MISO] = crossbar_enable_0_q[`PXB_X0_SYNC];
        sig_en[`PXB_SIG_MOSI] = crossbar_enable_0_q[`PXB_X0_SYNC];
        sig_en[`PXB_SIG_NSS] = crossbar_enable_0_q[`PXB_X0_SYNC] & sync_four_wire;
        sig_en[`PXB_SIG_SDA] = crossbar_enable_0_q[`PXB_X0_TWO_WIRE];
        sig_en[`PXB_SIG_SCL] = crossbar_enable_0_q[`PXB_X0_TWO_WIRE];
        for (i = 0; i < 6; i = i + 1)
            sig_en[`PXB_SIG_MOD0 + i] = line_en(array_module_count, i);
        sig_en[`PXB_SIG_EXT_CLK] = crossbar_enable_0_q[`PXB_X0_EXT_CLK];
        sig_en[`PXB_SIG_CMP_A] = crossbar_enable_0_q[`PXB_X0_CMP_A];
        sig_en[`PXB_SIG_CMP_B] = crossbar_enable_1_q[`PXB_X1_CMP_B];
        sig_en[`PXB_SIG_TMR_A] = crossbar_enable_1_q[`PXB_X1_TMR_A_CNT];
        sig_en[`PXB_SIG_IRQ_A] = crossbar_enable_1_q[`PXB_X1_IRQ_A];
        sig_en[`PXB_SIG_TMR_B] = crossbar_enable_1_q[`PXB_X1_TMR_B_CNT];
        sig_en[`PXB_SIG_IRQ_B] = crossbar_enable_1_q[`PXB_X1_IRQ_B];
        sig_en[`PXB_SIG_TMR_C] = crossbar_enable_1_q[`PXB_X1_TMR_C_CNT];
        sig_en[`PXB_SIG_TMR_C_CAP] = crossbar_enable_1_q[`PXB_X1_TMR_C_CAP];
        sig_en[`PXB_SIG_INV_CLK] = crossbar_enable_1_q[`PXB_X1_INV_CLK];
    end

    // analog-mode pins of ports 1 and 2 drop out of allocation
    always @* begin
        skip = {NPIN{1'b0}};
        skip[15:8] = ~port_b_input_mode_q;
        skip[23:16] = ~port_c_input_mode_q;
    end

    // rank of each enabled slot among the enabled ones
    // a disabled slot keeps the rank of the next one but never matches a pin
    always @* begin
        rank_cnt = 6'h00;
        sig_rank = {NSIG*5{1'b0}};
        for (i = 0; i < NSIG; i = i + 1) begin
            sig_rank[i*5 +: 5] = rank_cnt[4:0];
            if (sig_en[i])
                rank_cnt = rank_cnt + 6'h01;
        end
    end

    // the k-th free pin gets the slot of rank k; async port lands on 0 and 1
    // port 0 is never skipped, so the fixed async pins fall out of plain priority
    always @* begin
        pin_cnt = 6'h00;
        pin_map_d = {NPIN*5{1'b0}};
        pin_act_d = {NPIN{1'b0}};
        for (p = 0; p < NPIN; p = p + 1) begin
            if (!skip[p]) begin
                for (i = 0; i < NSIG; i = i + 1) begin
                    if (sig_en[i] && {1'b0, sig_rank[i*5 +: 5]} == pin_cnt) begin
                        pin_map_d[p*5 +: 5] = i[4:0];
                        pin_act_d[p] = 1'b1;
                    end
                end
                pin_cnt = pin_cnt + 6'h01;
            end
        end
        overflow_d = (rank_cnt > pin_cnt);
    end

    // the map is registered so a register write settles in one cycle
    // this also cuts the long comparison network off the pin paths
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_map_q <= {NPIN*5{1'b0}};
            pin_act_q <= {NPIN{1'b0}};
            overflow_q <= 1'b0;
        end else begin
            pin_map_q <= pin_map_d;
            pin_act_q <= pin_act_d;
            overflow_q <= overflow_d;
        end
    end

    // allocated pin count for the status register
    always @* begin
        used_cnt = 6'h00;
        for (p = 0; p < NPIN; p = p + 1)
            used_cnt = used_cnt + {5'h00, pin_act_q[p]};
    end

    // pin side: input-only slots never drive; nothing drives before global enable
    always @* begin
        pin_out = {NPIN{1'b0}};
        pin_oe = {NPIN{1'b0}};
        sel = 5'h00;
        for (p = 0; p < NPIN; p = p + 1) begin
            sel = map_field(pin_map_q, p);
            if (pin_act_q[p] && sel < NSIG) begin
                pin_out[p] = periph_out[sel];
                pin_oe[p] = crossbar_global_enable & periph_oe[sel]
                    & slot_drives(out_mask, sel);
            end
        end
    end

    // peripheral side: unrouted inputs idle high, so active-low irqs stay quiet
    // output slots read their own pin too, which a peripheral may use to sense contention
    always @* begin
        periph_in = {NSIG{1'b1}};
        for (p = 0; p < NPIN; p = p + 1) begin
            if (pin_act_q[p] && map_field(pin_map_q, p) < NSIG)
                periph_in[map_field(pin_map_q, p)] = pin_in[p];
        end
    end

endmodule // pxb_crossbar

// >>> tb/pxb_crossbar_assertions.sv
// checker: bus timing and routing properties of the port crossbar
module pxb_chk #(parameter AW = 10, parameter NPIN = 32, parameter NSIG = 24) (
    input wire mclk, // clock
    input wire reset, // async reset
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_we_i, // write
    input wire [AW-1:0] wb_adr_i, // address
    input wire [3:0] wb_sel_i, // lanes
    input wire [31:0] wb_dat_i, // wdata
    input wire [31:0] wb_dat_o, // rdata
    input wire wb_ack_o, // ack
    input wire wb_err_o, // err
    input wire [NSIG-1:0] periph_out, // slot drive
    input wire [NSIG-1:0] periph_oe, // slot enable
    input wire [NSIG-1:0] periph_in, // slot level
    input wire [NPIN-1:0] pin_in, // pin level
    input wire [NPIN-1:0] pin_out, // pin drive
    input wire [NPIN-1:0] pin_oe // pin enable
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [7:0] idx = wb_adr_i[9:2];
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire miss = !(idx inside {8'hE1, 8'hE2, 8'hE3, 8'hAD, 8'hAE, 8'hE8});
    logic [7:0] x0_q;
    logic [7:0] x1_q;
    logic glob_q;
    logic [1:0] quiet_q;
    // shadow of written state; pins follow one cycle late, so wait a cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            x0_q <= 8'h00;
            x1_q <= 8'h00;
            glob_q <= 1'b0;
            quiet_q <= 2'h3;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            if (idx == 8'hE1) x0_q <= wb_dat_i[7:0];
            if (idx == 8'hE2) x1_q <= wb_dat_i[7:0];
            if (idx == 8'hE3) glob_q <= wb_dat_i[6];
            quiet_q <= 2'h0;
        end else if (quiet_q != 2'h3) begin
            quiet_q <= quiet_q + 2'h1;
        end
    end
    wire calm = quiet_q != 2'h0;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_bus_answer: assert property (req |=> wb_ack_o ^ wb_err_o) else $error("no answer");
    a_err_unmapped: assert property (req |=> wb_err_o == miss) else $error("err wrong");
    a_read_value: assert property (wb_ack_o && !wb_we_i && (idx == 8'hE1 || idx == 8'hE2)
        |-> wb_dat_o == {24'h0, idx[0] ? x0_q : x1_q}) else $error("read data wrong");
    a_gate_off: assert property (!glob_q && !$past(glob_q) |-> pin_oe == '0)
        else $error("pin driven while disabled");
    a_tx_rx_fixed: assert property (calm && glob_q && x0_q[2] |-> pin_out[0] == periph_out[0]
        && pin_oe[0] == periph_oe[0] && periph_in[1] == pin_in[1] && !pin_oe[1])
        else $error("async pair misplaced");
    a_idle_map: assert property (calm && x0_q == 0 && x1_q == 0 |-> &periph_in
        && pin_oe == '0) else $error("routing with empty enables");
    a_inv_clk_first: assert property (calm && glob_q && x0_q == 0 && x1_q == 8'h80
        |-> pin_out[0] == periph_out[23] && pin_oe[0] == periph_oe[23]) else $error("clk pin");
    a_irq_a_first: assert property (calm && x0_q == 0 && x1_q == 8'h04
        |-> periph_in[18] == pin_in[0] && !pin_oe[0]) else $error("irq pin");
    c_err: cover property (wb_err_o);
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_inv_clk: cover property (calm && glob_q && x1_q == 8'h80);
endmodule // pxb_chk

bind pxb_crossbar pxb_chk #(.AW(AW), .NPIN(NPIN), .NSIG(NSIG)) chk_u (.*);

// >>> tb/pxb_crossbar_tb.sv
// self-checking bench for the port crossbar
`include "pxb_defs.vh"
module pxb_crossbar_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, ack, err, gerr;
    logic reset = 1, cyc = 0, stb = 0, we = 0, four = 0, gl = 0;
    logic [9:0] adr = 0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wd = 0, rd, got, po, pe, pin = 32'hA5C36E19;
    logic [23:0] pi, pout = 24'h3C96A5, poe = 24'hF7EFDF;
    logic [7:0] x0 = 0, x1 = 0, mb = 8'hFF, mc = 8'hFF;
    int n_fail = 0, checked = 0;
    pxb_crossbar dut_u (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
        .wb_ack_o(ack), .wb_err_o(err), .sync_four_wire(four), .periph_out(pout),
        .periph_oe(poe), .periph_in(pi), .pin_in(pin), .pin_out(po), .pin_oe(pe));
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    task automatic tally_and_finish();
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one classic cycle, held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] i, d);
        int k;
        @(posedge mclk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {i, 2'b00};
        wd <= {24'h0, d};
        for (k = 0; k < 20; k++) begin
            @(posedge mclk);
            if (ack || err) break;
        end
        if (k == 20) begin
            n_fail++;
            tally_and_finish();
        end
        got = rd;
        gerr = err;
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic rdc(input logic [7:0] i, e);
        wb(0, i, 8'h00);
        cmp(got, {24'h0, e});
    endtask
    // predicted allocation: enabled slots take the next non-skipped pin
    task automatic check_map();
        logic [23:0] en, epi, dm = `PXB_OUT_MASK;
        logic [31:0] eoe, sk;
        int p, n, na;
        logic ov;
        n = (x0[5:3] > 3'h6) ? 6 : x0[5:3];
        en = {x1, x0[7:6], 6'((1 << n) - 1), {2{x0[0]}}, x0[1] & four, {3{x0[1]}}, {2{x0[2]}}};
        sk = {8'h00, ~mc, ~mb, 8'h00};
        p = 0;
        na = 0;
        ov = 0;
        eoe = '0;
        epi = '1;
        for (int s = 0; s < 24; s++) begin
            while (p < 32 && sk[p]) p++;
            if (en[s] && p == 32) ov = 1;
            if (en[s] && p < 32) begin
                epi[s] = pin[p];
                eoe[p] = gl & poe[s] & dm[s];
                if (gl && dm[s]) cmp(po[p], pout[s]);
                p++;
                na++;
            end
        end
        cmp(pe, eoe);
        cmp(pi, epi);
        wb(0, 8'hE8, 8'h00);
        cmp(got, {25'h0, ov, 6'(na)});
    endtask
    task automatic cfg(input logic [7:0] a, b, input logic f);
        x0 = a;
        x1 = b;
        wb(1, 8'hE1, a);
        wb(1, 8'hE2, b);
        @(posedge mclk);
        four <= f;
        pin <= ~pin;
        pout <= ~pout;
        poe <= ~poe;
        repeat (2) @(posedge mclk);
        #1;
        check_map();
    endtask
    // reset values, ignored lane, unmapped index
    task automatic t_regs();
        #1;
        check_map();
        rdc(8'hE1, 8'h00);
        rdc(8'hE2, 8'h00);
        rdc(8'hAD, 8'hFF);
        rdc(8'hAE, 8'hFF);
        sel <= 4'hE;
        wb(1, 8'hE2, 8'h5A);
        sel <= 4'hF;
        rdc(8'hE2, 8'h00);
        wb(1, 8'h10, 8'hFF);
        cmp(gerr, 1'b1);
    endtask
    // drivers held off until the global bit is set
    task automatic t_gate();
        cfg(8'h04, 8'h00, 1'b0);
        gl = 1;
        wb(1, 8'hE3, 8'h40);
        repeat (2) @(posedge mclk);
        #1;
        check_map();
        rdc(8'hE3, 8'h40);
    endtask
    // each enable alone, every module count, both sync modes
    task automatic t_sweep();
        for (int b = 0; b < 8; b++) begin
            cfg(8'h01 << b, 8'h00, 1'b1);
            cfg(8'h00, 8'h01 << b, 1'b0);
            cfg(8'(b << 3), 8'h00, 1'b0);
        end
        cfg(8'h02, 8'h00, 1'b0);
    endtask
    // analog pins stepped over; a full request runs out of pins
    task automatic t_prio();
        mb = 8'hE3;
        wb(1, 8'hAD, mb);
        cfg(8'h3D, 8'h14, 1'b0);
        mb = 8'h00;
        mc = 8'h00;
        wb(1, 8'hAD, mb);
        wb(1, 8'hAE, mc);
        cfg(8'hFF, 8'hFF, 1'b1);
        rdc(8'hE1, 8'hFF);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_gate();
        t_sweep();
        t_prio();
        tally_and_finish();
    end
endmodule // pxb_crossbar_tb
